// *** design/acs_pkg.sv ***
package acs_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_BLANK  = 8'h00;
  localparam logic [7:0] ADDR_GROUP  = 8'h04;
  localparam logic [7:0] ADDR_CH1    = 8'h08;
  localparam logic [7:0] ADDR_CH2    = 8'h0c;
  localparam logic [7:0] ADDR_GAP    = 8'h10;
  localparam logic [7:0] ADDR_TCTL   = 8'h14;
  localparam logic [7:0] ADDR_PRE_LO = 8'h18;
  localparam logic [7:0] ADDR_PRE_HI = 8'h1c;
  localparam logic [7:0] ADDR_STAT   = 8'h20;
  localparam logic [7:0] ADDR_SUM1   = 8'h24;
  localparam logic [7:0] ADDR_SUM2   = 8'h28;
  localparam logic [7:0] ADDR_RES    = 8'h2c;

  // Field positions
  localparam int ARM_BIT     = 7;
  localparam int TSRC_LSB    = 6;
  localparam int RPT_BIT     = 4;
  localparam int PAIR_EN_BIT = 5;
  localparam int KIND_BIT    = 4;
  localparam int TON_BIT     = 4;
  localparam int EXT_BIT     = 1;
  localparam int PSC_BIT     = 0;
  localparam int DONE_BIT    = 0;
  localparam int BUSY_BIT    = 1;
  localparam int ARMED_BIT   = 2;
  localparam int CNT_LSB     = 8;

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Trigger source codes
  localparam logic [1:0] TSRC_PWM    = 2'b00;
  localparam logic [1:0] TSRC_EDGE   = 2'b01;
  localparam logic [1:0] TSRC_ARMTMR = 2'b10;
  localparam logic [1:0] TSRC_SOFT   = 2'b11;

  // Group size codes
  localparam logic [2:0] GRP_OFF = 3'h0;
  localparam logic [2:0] GRP_1   = 3'h1;
  localparam logic [2:0] GRP_2   = 3'h2;
  localparam logic [2:0] GRP_4   = 3'h3;
  localparam logic [2:0] GRP_8   = 3'h4;

  // Blanking unit in PWM clock periods, timer prescale ratios
  localparam int BLANK_UNIT = 16;
  localparam int TMR_DIV_LO = 4;
  localparam int TMR_DIV_HI = 8;

  // Channel codes
  localparam logic [3:0] EXT_MAX   = 4'ha;
  localparam logic [3:0] INT_AMP_A = 4'h1;
  localparam logic [3:0] INT_AMP_B = 4'h2;
  localparam logic [3:0] INT_NEG   = 4'h3;

  // Route kinds presented to the converter mux
  localparam logic [2:0] RT_EXT   = 3'h0;
  localparam logic [2:0] RT_BG    = 3'h1;
  localparam logic [2:0] RT_AMPA  = 3'h2;
  localparam logic [2:0] RT_AMPB  = 3'h3;
  localparam logic [2:0] RT_NEG   = 3'h4;
  localparam logic [2:0] RT_FLOAT = 3'h5;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_BLANK = 5'b00010,
    ST_CONV1 = 5'b00100,
    ST_GAP   = 5'b01000,
    ST_CONV2 = 5'b10000
  } acs_state_t;

  function automatic logic [4:0] acs_group_size(input logic [2:0] code);
    case (code)
      GRP_OFF: acs_group_size = 5'd0;
      GRP_1:   acs_group_size = 5'd1;
      GRP_2:   acs_group_size = 5'd2;
      GRP_4:   acs_group_size = 5'd4;
      GRP_8:   acs_group_size = 5'd8;
      default: acs_group_size = 5'd16;
    endcase
  endfunction : acs_group_size

  // Returns {kind, channel} for one pair-mode channel
  function automatic logic [6:0] acs_route(input logic kind, input logic [3:0] code);
    if (kind) begin
      acs_route = (code > EXT_MAX) ? {RT_FLOAT, code} : {RT_EXT, code};
    end else begin
      case (code)
        INT_AMP_A: acs_route = {RT_AMPA, code};
        INT_AMP_B: acs_route = {RT_AMPB, code};
        INT_NEG:   acs_route = {RT_NEG, code};
        default:   acs_route = {RT_BG, code};
      endcase
    end
  endfunction : acs_route

endpackage : acs_pkg

// *** design/acs_trig_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_trig_timer
  import acs_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             run,
  input  wire logic             load,
  input  wire logic             div_slow,
  input  wire logic [WIDTH-1:0] preload,
  output logic                  overflow,
  output logic [WIDTH-1:0]      count
);

  localparam logic [2:0] LIM_LO = 3'(TMR_DIV_LO - 1);
  localparam logic [2:0] LIM_HI = 3'(TMR_DIV_HI - 1);
  localparam logic [WIDTH-1:0] FULL = '1;

  logic [2:0] presc_r;
  logic       tick;

  assign tick = run && (presc_r == (div_slow ? LIM_HI : LIM_LO));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 3'h0;
    end else if (load || !run || tick) begin
      presc_r <= 3'h0;
    end else begin
      presc_r <= presc_r + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (load) begin
      count <= preload;
    end else if (tick) begin
      count <= (count == FULL) ? preload : count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow <= 1'b0;
    end else begin
      overflow <= tick && !load && (count == FULL);
    end
  end

endmodule : acs_trig_timer
`default_nettype wire

// *** design/acs_seq.sv ***
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acs_seq
  import acs_pkg::*;
#(
  parameter int TMR_WIDTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        first_pwm_output,
  input  wire logic        protection_comparator_out,
  input  wire logic        pwm_clk_tick,
  input  wire logic        adck_tick,
  input  wire logic        converter_busy_flag,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_data,
  output logic             conv_start,
  output logic             route_from_pair,
  output logic      [2:0]  route_kind,
  output logic      [3:0]  route_chan
);

  acs_state_t state_r;

  logic        auto_group_arm_r;
  logic [4:0]  blanking_time_code_r;
  logic [1:0]  trigger_source_select_r;
  logic        repeat_trigger_flag_r;
  logic [2:0]  group_count_select_r;
  logic        pair_mode_enable_r;
  logic        first_channel_source_kind_r;
  logic [3:0]  first_channel_signal_code_r;
  logic        second_channel_source_kind_r;
  logic [3:0]  second_channel_signal_code_r;
  logic [3:0]  pair_interval_code_r;
  logic        timer_run_enable_r;
  logic        edge_start_enable_r;
  logic        timer_clock_divide_select_r;
  logic [7:0]  preload_buf_r;
  logic [15:0] preload_r;
  logic        conversion_done_flag_r;
  logic [15:0] first_sum_r;
  logic [15:0] second_sum_r;
  logic [7:0]  result_high_byte_r;
  logic [7:0]  result_low_byte_r;
  logic [9:0]  wait_cnt_r;
  logic [4:0]  conv_cnt_r;
  logic        sel_second_r;
  logic        pwm_prev_r;
  logic        comp_prev_r;
  logic        arm_prev_r;

  logic        setup;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        pwm_rise;
  logic        comp_rise;
  logic        arm_rise;
  logic        arm_fall;
  logic        armed;
  logic        src_evt;
  logic        trig;
  logic        step_end;
  logic        group_end;
  logic        timer_set;
  logic        timer_ovf;
  logic [4:0]  group_n;

  assign setup     = psel && !penable;
  assign wr        = psel && penable && pready && pwrite;
  assign rd        = psel && penable && pready && !pwrite;
  assign pwm_rise  = first_pwm_output && !pwm_prev_r;
  assign comp_rise = protection_comparator_out && !comp_prev_r;
  assign arm_rise  = auto_group_arm_r && !arm_prev_r;
  assign arm_fall  = !auto_group_arm_r && arm_prev_r;
  assign group_n   = acs_group_size(group_count_select_r);
  assign armed     = auto_group_arm_r && (group_n != 5'd0);

  always_comb begin
    case (trigger_source_select_r)
      TSRC_PWM:    src_evt = pwm_rise;
      TSRC_EDGE:   src_evt = timer_ovf;
      TSRC_ARMTMR: src_evt = timer_ovf;
      TSRC_SOFT:   src_evt = arm_rise;
      default:     src_evt = 1'b0;
    endcase
  end

  assign trig      = armed && src_evt;
  assign step_end  = conv_done && ((state_r == ST_CONV2) || (state_r == ST_CONV1 && !pair_mode_enable_r));
  assign group_end = step_end && armed && ((conv_cnt_r + 5'd1) == group_n);

  assign timer_set = (trigger_source_select_r == TSRC_EDGE && comp_rise && edge_start_enable_r
                      && !converter_busy_flag)
                     || (trigger_source_select_r == TSRC_ARMTMR && arm_rise && armed);

  always_comb begin
    case (paddr)
      ADDR_BLANK, ADDR_GROUP, ADDR_CH1, ADDR_CH2, ADDR_GAP, ADDR_TCTL,
      ADDR_PRE_LO, ADDR_PRE_HI, ADDR_STAT, ADDR_SUM1, ADDR_SUM2, ADDR_RES: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: no wait state, read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        case (paddr)
          ADDR_BLANK:  prdata <= {24'h0, auto_group_arm_r, 2'b00, blanking_time_code_r};
          ADDR_GROUP:  prdata <= {24'h0, trigger_source_select_r, 1'b0, repeat_trigger_flag_r,
                                  1'b0, group_count_select_r};
          ADDR_CH1:    prdata <= {24'h0, 2'b00, pair_mode_enable_r, first_channel_source_kind_r,
                                  first_channel_signal_code_r};
          ADDR_CH2:    prdata <= {24'h0, 3'b000, second_channel_source_kind_r, second_channel_signal_code_r};
          ADDR_GAP:    prdata <= {28'h0, pair_interval_code_r};
          ADDR_TCTL:   prdata <= {24'h0, 3'b000, timer_run_enable_r, 2'b00, edge_start_enable_r,
                                  timer_clock_divide_select_r};
          ADDR_PRE_LO: prdata <= {24'h0, preload_buf_r};
          ADDR_PRE_HI: prdata <= {24'h0, preload_r[15:8]};
          ADDR_STAT:   prdata <= {19'h0, conv_cnt_r, 5'h0, armed, converter_busy_flag,
                                  conversion_done_flag_r};
          ADDR_SUM1:   prdata <= {16'h0, first_sum_r};
          ADDR_SUM2:   prdata <= {16'h0, second_sum_r};
          ADDR_RES:    prdata <= {16'h0, result_high_byte_r, result_low_byte_r};
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_prev_r  <= 1'b0;
      comp_prev_r <= 1'b0;
      arm_prev_r  <= 1'b0;
    end else begin
      pwm_prev_r  <= first_pwm_output;
      comp_prev_r <= protection_comparator_out;
      arm_prev_r  <= auto_group_arm_r;
    end
  end

  // Plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blanking_time_code_r         <= 5'h00;
      trigger_source_select_r      <= 2'b00;
      group_count_select_r         <= 3'h0;
      pair_mode_enable_r           <= 1'b0;
      first_channel_source_kind_r  <= 1'b0;
      first_channel_signal_code_r  <= 4'h0;
      second_channel_source_kind_r <= 1'b0;
      second_channel_signal_code_r <= 4'h0;
      pair_interval_code_r         <= 4'h0;
      edge_start_enable_r          <= 1'b0;
      timer_clock_divide_select_r  <= 1'b0;
    end else if (wr) begin
      case (paddr)
        ADDR_BLANK: blanking_time_code_r <= pwdata[4:0];
        ADDR_GROUP: begin
          trigger_source_select_r <= pwdata[TSRC_LSB+:2];
          group_count_select_r    <= pwdata[2:0];
        end
        ADDR_CH1: begin
          pair_mode_enable_r          <= pwdata[PAIR_EN_BIT];
          first_channel_source_kind_r <= pwdata[KIND_BIT];
          first_channel_signal_code_r <= pwdata[3:0];
        end
        ADDR_CH2: begin
          second_channel_source_kind_r <= pwdata[KIND_BIT];
          second_channel_signal_code_r <= pwdata[3:0];
        end
        ADDR_GAP: pair_interval_code_r <= pwdata[3:0];
        ADDR_TCTL: begin
          edge_start_enable_r         <= pwdata[EXT_BIT];
          timer_clock_divide_select_r <= pwdata[PSC_BIT];
        end
        default: ;
      endcase
    end
  end

  // Arm bit: software write wins over the end-of-group clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_group_arm_r <= 1'b0;
    end else if (wr && paddr == ADDR_BLANK) begin
      auto_group_arm_r <= pwdata[ARM_BIT];
    end else if (group_end) begin
      auto_group_arm_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      repeat_trigger_flag_r <= 1'b0;
    end else if (arm_rise) begin
      repeat_trigger_flag_r <= 1'b0;
    end else if (trig && state_r != ST_IDLE) begin
      repeat_trigger_flag_r <= 1'b1;
    end else if (wr && paddr == ADDR_GROUP && !pwdata[RPT_BIT]) begin
      repeat_trigger_flag_r <= 1'b0;
    end
  end

  // Timer enable: hardware sets, software can only clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_run_enable_r <= 1'b0;
    end else if (timer_set) begin
      timer_run_enable_r <= 1'b1;
    end else if (timer_ovf && trigger_source_select_r == TSRC_EDGE) begin
      timer_run_enable_r <= 1'b0;
    end else if (arm_fall && trigger_source_select_r == TSRC_ARMTMR) begin
      timer_run_enable_r <= 1'b0;
    end else if (wr && paddr == ADDR_TCTL && !pwdata[TON_BIT]) begin
      timer_run_enable_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preload_buf_r <= RST_BYTE;
      preload_r     <= RST_WORD;
    end else if (wr && paddr == ADDR_PRE_LO) begin
      preload_buf_r <= pwdata[7:0];
    end else if (wr && paddr == ADDR_PRE_HI) begin
      preload_r <= {pwdata[7:0], preload_buf_r};
    end else if (rd && paddr == ADDR_PRE_HI) begin
      preload_buf_r <= preload_r[7:0];
    end
  end

  acs_trig_timer #(
    .WIDTH (TMR_WIDTH)
  ) u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (timer_run_enable_r),
    .load     (timer_set && !timer_run_enable_r),
    .div_slow (timer_clock_divide_select_r),
    .preload  (preload_r),
    .overflow (timer_ovf),
    .count    ()
  );

  // Conversion sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= ST_IDLE;
      wait_cnt_r   <= 10'h000;
      conv_start   <= 1'b0;
      sel_second_r <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          sel_second_r <= 1'b0;
          if (trig) begin
            if (trigger_source_select_r == TSRC_PWM) begin
              wait_cnt_r <= 10'(({1'b0, blanking_time_code_r} + 6'd1) * BLANK_UNIT);
              state_r    <= ST_BLANK;
            end else begin
              conv_start <= 1'b1;
              state_r    <= ST_CONV1;
            end
          end
        end
        ST_BLANK: begin
          if (!armed) begin
            state_r <= ST_IDLE;
          end else if (pwm_clk_tick && wait_cnt_r == 10'h001) begin
            conv_start <= 1'b1;
            state_r    <= ST_CONV1;
          end else if (pwm_clk_tick) begin
            wait_cnt_r <= wait_cnt_r - 10'h001;
          end
        end
        ST_CONV1: begin
          if (!armed) begin
            state_r <= ST_IDLE;
          end else if (conv_done && pair_mode_enable_r) begin
            wait_cnt_r   <= {6'h00, pair_interval_code_r} + 10'h001;
            sel_second_r <= 1'b1;
            state_r      <= ST_GAP;
          end else if (conv_done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_GAP: begin
          if (!armed) begin
            state_r <= ST_IDLE;
          end else if (adck_tick && wait_cnt_r == 10'h001) begin
            conv_start <= 1'b1;
            state_r    <= ST_CONV2;
          end else if (adck_tick) begin
            wait_cnt_r <= wait_cnt_r - 10'h001;
          end
        end
        ST_CONV2: begin
          if (!armed || conv_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt_r <= 5'h00;
    end else if (arm_rise || group_end) begin
      conv_cnt_r <= 5'h00;
    end else if (step_end && armed) begin
      conv_cnt_r <= conv_cnt_r + 5'h01;
    end
  end

  // Accumulation and result bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_sum_r        <= RST_WORD;
      second_sum_r       <= RST_WORD;
      result_high_byte_r <= RST_BYTE;
      result_low_byte_r  <= RST_BYTE;
    end else if (arm_rise) begin
      first_sum_r  <= RST_WORD;
      second_sum_r <= RST_WORD;
    end else if (conv_done && armed && state_r == ST_CONV1) begin
      first_sum_r        <= first_sum_r + {4'h0, conv_data};
      result_high_byte_r <= {4'h0, conv_data[11:8]};
      result_low_byte_r  <= conv_data[7:0];
    end else if (conv_done && armed && state_r == ST_CONV2) begin
      second_sum_r       <= second_sum_r + {4'h0, conv_data};
      result_high_byte_r <= {4'h0, conv_data[11:8]};
      result_low_byte_r  <= conv_data[7:0];
    end
  end

  // Done flag: set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag_r <= 1'b0;
    end else if (group_end) begin
      conversion_done_flag_r <= 1'b1;
    end else if (wr && paddr == ADDR_STAT && !pwdata[DONE_BIT]) begin
      conversion_done_flag_r <= 1'b0;
    end
  end

  // Converter input routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_from_pair <= 1'b0;
      route_kind      <= RT_BG;
      route_chan      <= 4'h0;
    end else begin
      route_from_pair <= pair_mode_enable_r;
      if (sel_second_r) begin
        {route_kind, route_chan} <= acs_route(second_channel_source_kind_r,
                                              second_channel_signal_code_r);
      end else begin
        {route_kind, route_chan} <= acs_route(first_channel_source_kind_r,
                                              first_channel_signal_code_r);
      end
    end
  end

endmodule : acs_seq
`default_nettype wire

// *** bench/acs_conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_conv_model (
  input  wire logic        pclk,
  input  wire logic        conv_start,
  input  wire logic        slow,
  input  wire logic [11:0] cdata,
  output logic             converter_busy_flag,
  output logic             conv_done,
  output logic      [11:0] conv_data
);
  int left = 0;

  initial begin
    converter_busy_flag = 1'b0;
    conv_done = 1'b0;
    conv_data = 12'h000;
  end

  // Data toggles outside the done pulse so the value one cycle after the pulse never matches
  always @(posedge pclk) begin
    conv_done <= left == 1;
    conv_data <= (left == 1) ? cdata : ~conv_data;
    converter_busy_flag <= conv_start || left > 1;
    left <= conv_start ? (slow ? 20 : 4) : (left > 0 ? left - 1 : 0);
  end
endmodule : acs_conv_model
`default_nettype wire

// *** bench/acs_seq_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_seq_sva
  import acs_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        converter_busy_flag,
  input wire logic        conv_start,
  input wire logic        route_from_pair,
  input wire logic [2:0]  route_kind,
  input wire logic [3:0]  route_chan
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
  AST_PAIR_BIT: assert property (psel && penable && pready && pwrite && paddr == ADDR_CH1
    |-> ##2 route_from_pair == $past(pwdata[PAIR_EN_BIT], 2)) else $error("pair mode not set");
  AST_EXT_RANGE: assert property (route_from_pair && route_kind == RT_EXT |-> route_chan <= EXT_MAX)
    else $error("external code out of range");
  AST_FLOAT_RANGE: assert property (route_kind == RT_FLOAT |-> route_chan > EXT_MAX)
    else $error("floating for a valid code");
  AST_AMP_CODE: assert property (route_kind == RT_AMPB |-> route_chan == INT_AMP_B)
    else $error("amp b for wrong code");
  AST_START_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  AST_START_IDLE: assert property (conv_start |-> !converter_busy_flag)
    else $error("start while converter busy");

  cover property (conv_start && route_from_pair);
  cover property (pslverr);
  cover property (conv_start && !route_from_pair);
endmodule : acs_seq_sva

bind acs_seq acs_seq_sva u_sva (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .converter_busy_flag, .conv_start, .route_from_pair, .route_kind, .route_chan);
`default_nettype wire

// *** bench/tb_acs_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_acs_seq
  import acs_pkg::*;
;
  localparam logic [11:0] DAT = 12'h9a5;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        first_pwm_output, protection_comparator_out, pwm_clk_tick, adck_tick;
  logic        converter_busy_flag, conv_done, conv_start, route_from_pair;
  logic [11:0] conv_data;
  logic [2:0]  route_kind;
  logic [3:0]  route_chan;
  logic [6:0]  rt [$];
  int          failures, checks_done, cyc, starts, st_cyc, dn_cyc, ec, s0, gap;

  acs_seq dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .first_pwm_output, .protection_comparator_out, .pwm_clk_tick, .adck_tick, .converter_busy_flag,
    .conv_done, .conv_data, .conv_start, .route_from_pair, .route_kind, .route_chan);
  acs_conv_model conv (.pclk, .conv_start, .slow, .cdata(DAT), .converter_busy_flag, .conv_done, .conv_data);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc          <= cyc + 1;
    pwm_clk_tick <= ~pwm_clk_tick;
    adck_tick    <= cyc[0];
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
      st_cyc <= cyc;
      gap    <= cyc - dn_cyc;
      rt.push_back({route_kind, route_chan});
    end
    if (conv_done === 1'b1) dn_cyc <= cyc;
    if (cyc > 6000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("unexpected t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic kick(input logic cmp);
    if (cmp) protection_comparator_out <= 1'b1;
    else first_pwm_output <= 1'b1;
    ec = cyc;
    repeat (3) @(posedge pclk);
    protection_comparator_out <= 1'b0;
    first_pwm_output <= 1'b0;
    @(posedge pclk);
  endtask : kick

  // Until k starts seen and the last one has finished
  task automatic ws(input int k);
    while (starts < k || dn_cyc <= st_cyc) begin
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask : ws

  task automatic t_regs;
    apb(0, ADDR_CH1, 0);
    chk(r, 0);
    apb(0, 8'h30, 0);
    chk(r, 0);
    chk(err, 1);
    apb(1, ADDR_CH2, 32'hff);
    apb(0, ADDR_CH2, 0);
    chk(r, 32'h1f);
    apb(1, ADDR_TCTL, 32'h13);
    apb(0, ADDR_TCTL, 0);
    chk(r, 32'h03);
    $display("regs done");
  endtask : t_regs

  task automatic t_zero;
    s0 = starts;
    apb(1, ADDR_GROUP, 32'hc0);
    apb(1, ADDR_BLANK, 32'h80);
    repeat (20) @(posedge pclk);
    chk(starts, s0);
    apb(1, ADDR_BLANK, 0);
    $display("zero count done");
  endtask : t_zero

  task automatic t_single;
    s0 = starts;
    apb(1, ADDR_GROUP, 32'hc1);
    apb(1, ADDR_BLANK, 32'h80);
    ws(s0 + 1);
    chk(starts, s0 + 1);
    apb(0, ADDR_SUM1, 0);
    chk(r, DAT);
    apb(0, ADDR_RES, 0);
    chk(r, DAT);
    apb(0, ADDR_STAT, 0);
    chk(r[2:0], 3'b001);
    apb(0, ADDR_BLANK, 0);
    chk(r, 0);
    $display("single done");
  endtask : t_single

  task automatic t_pwm;
    int e1;
    s0 = starts;
    apb(1, ADDR_GROUP, 32'h02);
    apb(1, ADDR_BLANK, 32'h81);
    kick(0);
    e1 = ec;
    kick(0);
    apb(0, ADDR_GROUP, 0);
    chk(r[RPT_BIT], 1);
    ws(s0 + 1);
    chk(st_cyc - e1 inside {[64:72]}, 1);
    kick(0);
    ws(s0 + 2);
    apb(0, ADDR_SUM1, 0);
    chk(r, 2 * DAT);
    $display("pwm done");
  endtask : t_pwm

  task automatic t_pair;
    s0 = starts;
    slow <= 1'b1;
    apb(1, ADDR_GROUP, 32'hd1);
    apb(1, ADDR_CH1, 32'h33);
    apb(1, ADDR_CH2, 32'h02);
    apb(1, ADDR_GAP, 32'h03);
    apb(1, ADDR_BLANK, 32'h80);
    apb(0, ADDR_GROUP, 0);
    chk(r[RPT_BIT], 0);
    ws(s0 + 2);
    chk({rt[s0], rt[s0 + 1]}, {RT_EXT, 4'h3, RT_AMPB, 4'h2});
    chk(gap inside {[7:11]}, 1);
    apb(0, ADDR_SUM2, 0);
    chk(r, DAT);
    apb(1, ADDR_CH1, 0);
    slow <= 1'b0;
    $display("pair done");
  endtask : t_pair

  task automatic t_timer;
    logic [7:0] lo [2] = '{8'hf0, 8'hf8};
    apb(1, ADDR_GROUP, 32'h41);
    apb(1, ADDR_TCTL, 0);
    kick(1);
    apb(0, ADDR_TCTL, 0);
    chk(r[TON_BIT], 0);
    for (int i = 0; i < 2; i++) begin
      s0 = starts;
      apb(1, ADDR_PRE_LO, {24'h0, lo[i]});
      apb(1, ADDR_PRE_HI, 32'hff);
      apb(1, ADDR_PRE_LO, 0);
      apb(0, ADDR_PRE_HI, 0);
      apb(0, ADDR_PRE_LO, 0);
      chk(r, {24'h0, lo[i]});
      apb(1, ADDR_TCTL, 32'(2 + i));
      apb(1, ADDR_BLANK, 32'h80);
      kick(1);
      apb(0, ADDR_TCTL, 0);
      chk(r[TON_BIT], 1);
      ws(s0 + 1);
      chk(st_cyc - ec inside {[64:76]}, 1);
      apb(0, ADDR_TCTL, 0);
      chk(r[TON_BIT], 0);
    end
    apb(1, ADDR_GROUP, 32'h81);
    apb(1, ADDR_BLANK, 32'h80);
    apb(0, ADDR_TCTL, 0);
    chk(r[TON_BIT], 1);
    apb(1, ADDR_BLANK, 0);
    apb(0, ADDR_TCTL, 0);
    chk(r[TON_BIT], 0);
    $display("timer done");
  endtask : t_timer

  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    {psel, penable, pwrite, first_pwm_output, protection_comparator_out} = '0;
    {pwm_clk_tick, adck_tick, slow, paddr, pwdata} = '0;
    {failures, checks_done, cyc, starts, st_cyc, dn_cyc} = '0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_zero();
    t_single();
    t_pwm();
    t_pair();
    t_timer();
    wrap_up();
  end
endmodule : tb_acs_seq
`default_nettype wire
